// ===== hdl/eirc_top.sv
// external interrupt setting and reset cause/status register bank
// Function
// [RULE1] sensitivity codes 001 rise, 010 fall, 011 both, 101 high, 110 low
// [RULE2] wake select bit: 0 typical interrupt, 1 stop-mode wake-up
// [RULE3] pins two and three work like pin one, each own fields
// [RULE4] nmi cause field: 00 pin, 01 watchdog, 10 store bus error
// [RULE5] watchdog reset sets its flag; software clears it by writing 0
// [RULE6] mask part: bits 7..5 survive watchdog reset, cleared by external
// [RULE7] flash part: bits 7..5 survive normal reset, cleared by power-on
// [RULE8] flash part: reset-type bit written by software, cleared by power-on
// [RULE9] busy flag high while clock settings apply after activation
// [RULE10] flash part: inhibit bit blocks flash reinit on normal resets
// [RULE11] software writes both unlock codes alone to activation register
// [RULE12] pins are synchronised before edge or level detection
`timescale 1ns/1ps
`include "eirc_map.svh"
module eirc_top #(
   parameter bit FLASH_VARIANT = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_irq_pin_1,
   input wire logic ext_irq_pin_2,
   input wire logic ext_irq_pin_3,
   input wire logic ext_reset_n,
   input wire logic wdt_reset,
   input wire logic nmi_event,
   input wire logic [1:0] nmi_source,
   input wire logic cg_activate,
   input wire logic stop_mode,
   output logic [2:0] ext_irq_event,
   output logic stop_wake,
   output logic cg_update_pending,
   output logic flash_reset_inhibit,
   output logic irq
);
   localparam logic [3:0] SETTLE_CYC = 4'(`EIRC_CG_SETTLE_CYC);

   logic ext_rst_s1;
   logic ext_rst_s2;
   logic ext_rst;
   logic normal_rst;
   logic sticky_clr;
   logic [2:0] pins;
   logic [2:0] ev;
   logic [2:0] wake;
   eirc_pkg::eirc_setting_t setting [3];
   logic reset_type_marker;
   logic watchdog_reset_flag;
   logic [1:0] nmi_cause;
   logic [3:0] settle_cnt;
   logic [4:0] irq_status;
   logic [4:0] irq_enable;
   logic [4:0] irq_set;
   logic [4:0] irq_clr;
   logic access;
   logic wr_en;
   logic hit;
   logic [7:0] misc_rd;
   logic [31:0] rd_data;

   function automatic logic addr_is(input logic [11:0] a,
                                    input logic [31:0] idx);
      addr_is = (a == {idx[9:0], 2'b00});
   endfunction : addr_is

   // -----------------------------------------------------------------
   // reset sources
   // -----------------------------------------------------------------
   // presetn is the power-on reset; the pin reset is synchronised
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_rst_s1 <= 1'b0;
         ext_rst_s2 <= 1'b0;
      end else begin
         ext_rst_s1 <= ~ext_reset_n;
         ext_rst_s2 <= ext_rst_s1;
      end
   end

   assign ext_rst = ext_rst_s2;
   assign normal_rst = ext_rst | wdt_reset;
   // flash part keeps bits 7..5 until power-on; mask part until external
   assign sticky_clr = FLASH_VARIANT ? 1'b0 : ext_rst; // RULE6 RULE7

   // -----------------------------------------------------------------
   // apb slave
   // -----------------------------------------------------------------
   // one wait state: pready is registered so all outputs leave flops
   assign access = psel & penable;
   assign wr_en = access & pready & pwrite;
   assign hit = addr_is(paddr, `EIRC_IDX_MISC) |
                addr_is(paddr, `EIRC_IDX_EXT_IRQ_PIN_1) |
                addr_is(paddr, `EIRC_IDX_EXT_IRQ_PIN_2) |
                addr_is(paddr, `EIRC_IDX_EXT_IRQ_PIN_3) |
                addr_is(paddr, `EIRC_IDX_STAT) |
                addr_is(paddr, `EIRC_IDX_IEN) |
                addr_is(paddr, `EIRC_IDX_ICLR);

   always_comb begin
      misc_rd = 8'h00;
      misc_rd[`EIRC_MISC_TYPE] = FLASH_VARIANT & reset_type_marker;
      misc_rd[`EIRC_MISC_FRI] = FLASH_VARIANT & flash_reset_inhibit;
      misc_rd[`EIRC_MISC_WDR] = watchdog_reset_flag;
      misc_rd[`EIRC_MISC_NMI_MSB:`EIRC_MISC_NMI_LSB] = nmi_cause; // RULE4
      misc_rd[`EIRC_MISC_BUSY] = cg_update_pending; // RULE9
      rd_data = 32'h0000_0000;
      if (addr_is(paddr, `EIRC_IDX_MISC)) begin
         rd_data[7:0] = misc_rd;
      end
      for (int i = 0; i < 3; i++) begin
         if (addr_is(paddr, `EIRC_IDX_EXT_IRQ_PIN_1 + 32'(i))) begin
            rd_data[`EIRC_SEN_MSB:`EIRC_SEN_LSB] = setting[i].sensitivity;
            rd_data[`EIRC_WAKE_BIT] = setting[i].wake_select;
         end
      end
      if (addr_is(paddr, `EIRC_IDX_STAT)) begin
         rd_data[4:0] = irq_status;
      end
      if (addr_is(paddr, `EIRC_IDX_IEN)) begin
         rd_data[4:0] = irq_enable;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & ~hit;
         prdata <= (access & ~pready & ~pwrite) ? rd_data : 32'h0000_0000;
      end
   end

   // -----------------------------------------------------------------
   // external interrupt settings and detectors
   // -----------------------------------------------------------------
   assign pins = {ext_irq_pin_3, ext_irq_pin_2, ext_irq_pin_1};

   generate
      for (genvar g = 0; g < 3; g++) begin : g_pin // RULE3
         // writes ignored while clock settings are still applying
         always_ff @(posedge pclk or negedge presetn) begin // RULE9
            if (!presetn) begin
               setting[g] <= eirc_pkg::eirc_setting_t'(4'h0);
            end else if (normal_rst) begin
               setting[g] <= eirc_pkg::eirc_setting_t'(4'h0);
            end else if (wr_en && !cg_update_pending &&
                         addr_is(paddr, `EIRC_IDX_EXT_IRQ_PIN_1 + 32'(g))) begin
               setting[g].sensitivity <=
                  pwdata[`EIRC_SEN_MSB:`EIRC_SEN_LSB];
               setting[g].wake_select <= pwdata[`EIRC_WAKE_BIT];
            end
         end

         assign wake[g] = setting[g].wake_select;

         eirc_pin_detect u_det (
            .pclk(pclk),
            .presetn(presetn),
            .pin(pins[g]),
            .sens(setting[g].sensitivity),
            .event_hit(ev[g])
         );
      end
   endgenerate

   // wake-up only from inputs whose own select bit is set
   always_ff @(posedge pclk or negedge presetn) begin // RULE2 RULE3
      if (!presetn) begin
         ext_irq_event <= 3'h0;
         stop_wake <= 1'b0;
      end else begin
         ext_irq_event <= ev & ~wake;
         stop_wake <= stop_mode & |(ev & wake);
      end
   end

   // -----------------------------------------------------------------
   // reset cause register
   // -----------------------------------------------------------------
   // a watchdog reset in the same cycle as a clear write wins
   always_ff @(posedge pclk or negedge presetn) begin // RULE5
      if (!presetn) begin
         watchdog_reset_flag <= 1'b0;
      end else if (wdt_reset) begin
         watchdog_reset_flag <= 1'b1;
      end else if (sticky_clr) begin
         watchdog_reset_flag <= 1'b0;
      end else if (wr_en && addr_is(paddr, `EIRC_IDX_MISC) &&
                   !pwdata[`EIRC_MISC_WDR]) begin
         watchdog_reset_flag <= 1'b0;
      end
   end

   // normal resets never touch these; only power-on or a software write clears them
   always_ff @(posedge pclk or negedge presetn) begin // RULE8 RULE10
      if (!presetn) begin
         reset_type_marker <= 1'b0;
         flash_reset_inhibit <= 1'b0;
      end else if (!FLASH_VARIANT) begin
         reset_type_marker <= 1'b0;
         flash_reset_inhibit <= 1'b0;
      end else if (wr_en && addr_is(paddr, `EIRC_IDX_MISC)) begin
         reset_type_marker <= pwdata[`EIRC_MISC_TYPE];
         flash_reset_inhibit <= pwdata[`EIRC_MISC_FRI];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin // RULE4
      if (!presetn) begin
         nmi_cause <= `EIRC_RST_NMI;
      end else if (nmi_event) begin
         nmi_cause <= nmi_source;
      end else if (ext_rst) begin
         nmi_cause <= `EIRC_RST_NMI;
      end
   end

   // busy for the settle time after each activation
   always_ff @(posedge pclk or negedge presetn) begin // RULE9
      if (!presetn) begin
         settle_cnt <= 4'h0;
         cg_update_pending <= 1'b0;
      end else if (cg_activate) begin
         settle_cnt <= SETTLE_CYC;
         cg_update_pending <= 1'b1;
      end else if (settle_cnt != 4'h0) begin
         settle_cnt <= settle_cnt - 4'h1;
         cg_update_pending <= (settle_cnt > 4'h1);
      end
   end

   // -----------------------------------------------------------------
   // interrupt status, enable, clear
   // -----------------------------------------------------------------
   always_comb begin
      irq_set = {nmi_event, wdt_reset, ev};
      irq_clr = 5'h00;
      if (wr_en && addr_is(paddr, `EIRC_IDX_ICLR)) begin
         irq_clr = pwdata[4:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= `EIRC_RST_IRQ;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable <= `EIRC_RST_IRQ;
      end else if (wr_en && addr_is(paddr, `EIRC_IDX_IEN)) begin
         irq_enable <= pwdata[4:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_enable);
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_busy_rise;
      cg_activate |=> cg_update_pending;
   endproperty
   a_busy_rise: assert property (p_busy_rise) // RULE9
      else $error("busy flag not raised by activation");

   property p_busy_end;
      cg_activate ##1 (!cg_activate)[*8] |=> !cg_update_pending;
   endproperty
   a_busy_end: assert property (p_busy_end) // RULE9
      else $error("busy flag outlasted the settle time");

   property p_busy_block;
      wr_en && cg_update_pending && addr_is(paddr, `EIRC_IDX_EXT_IRQ_PIN_3) &&
      !normal_rst |=> $stable(setting[2]);
   endproperty
   a_busy_block: assert property (p_busy_block) // RULE9
      else $error("setting changed while clock update pending");

   property p_wdr_set;
      wdt_reset |=> watchdog_reset_flag ##1
         (watchdog_reset_flag || $past(wr_en) || $past(sticky_clr));
   endproperty
   a_wdr_set: assert property (p_wdr_set) // RULE5
      else $error("watchdog flag not set or lost");

   property p_mask_ext_clr;
      !FLASH_VARIANT && ext_rst && !wdt_reset |=> !watchdog_reset_flag;
   endproperty
   a_mask_ext_clr: assert property (p_mask_ext_clr) // RULE6
      else $error("external reset left watchdog flag set");

   property p_flash_keep;
      FLASH_VARIANT && normal_rst && !wr_en |=>
         $stable(reset_type_marker) && $stable(flash_reset_inhibit) &&
         (watchdog_reset_flag || !$past(watchdog_reset_flag));
   endproperty
   a_flash_keep: assert property (p_flash_keep) // RULE7
      else $error("normal reset disturbed sticky bits");

   property p_marker_write;
      FLASH_VARIANT && wr_en && addr_is(paddr, `EIRC_IDX_MISC) |=>
         reset_type_marker == $past(pwdata[`EIRC_MISC_TYPE]);
   endproperty
   a_marker_write: assert property (p_marker_write) // RULE8
      else $error("reset type bit did not take written value");

   property p_nmi_cause;
      nmi_event |=> nmi_cause == $past(nmi_source);
   endproperty
   a_nmi_cause: assert property (p_nmi_cause) // RULE4
      else $error("nmi cause not captured");

   property p_wake_sel;
      ev[1] && stop_mode && wake[1] |=> stop_wake && !ext_irq_event[1];
   endproperty
   a_wake_sel: assert property (p_wake_sel) // RULE2 RULE3
      else $error("stop wake does not follow wake select");

   property p_irq_out;
      |(irq_status & irq_enable) |=> irq;
   endproperty
   a_irq_out: assert property (p_irq_out)
      else $error("enabled status did not raise irq");

   c_wdt: cover property (wdt_reset ##1 watchdog_reset_flag);
   c_wake: cover property (stop_wake);
   c_busy_done: cover property ($fell(cg_update_pending));
   c_irq: cover property ($rose(irq));
endmodule : eirc_top

// ===== hdl/eirc_map.svh
// register map, field positions, reset values and timing counts
`ifndef EIRC_MAP_SVH
`define EIRC_MAP_SVH

// -----------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define EIRC_IDX_MISC 32'hffffd30d
`define EIRC_IDX_EXT_IRQ_PIN_1 32'hffffd31b
`define EIRC_IDX_EXT_IRQ_PIN_2 32'hffffd31c
`define EIRC_IDX_EXT_IRQ_PIN_3 32'hffffd31d
`define EIRC_IDX_STAT 32'hffffd320
`define EIRC_IDX_IEN 32'hffffd321
`define EIRC_IDX_ICLR 32'hffffd322

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define EIRC_RST_SETTING 8'h00
`define EIRC_RST_NMI 2'h0
`define EIRC_RST_IRQ 5'h00

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define EIRC_SEN_MSB 7
`define EIRC_SEN_LSB 5
`define EIRC_WAKE_BIT 3
`define EIRC_MISC_TYPE 7
`define EIRC_MISC_FRI 6
`define EIRC_MISC_WDR 5
`define EIRC_MISC_NMI_MSB 2
`define EIRC_MISC_NMI_LSB 1
`define EIRC_MISC_BUSY 0
`define EIRC_ST_WDT 3
`define EIRC_ST_NMI 4

// -----------------------------------------------------------------
// sensitivity codes and nmi causes
// -----------------------------------------------------------------
`define EIRC_SEN_RISE 3'h1
`define EIRC_SEN_FALL 3'h2
`define EIRC_SEN_BOTH 3'h3
`define EIRC_SEN_HIGH 3'h5
`define EIRC_SEN_LOW 3'h6
`define EIRC_NMI_PIN 2'h0
`define EIRC_NMI_WDT 2'h1
`define EIRC_NMI_BUSERR 2'h2

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define EIRC_CLK_NS 25
`define EIRC_CG_SETTLE_NS 200
`define EIRC_CG_SETTLE_CYC \
   ((`EIRC_CG_SETTLE_NS + `EIRC_CLK_NS - 1) / `EIRC_CLK_NS)

`endif

// ===== hdl/eirc_pkg.sv
// types shared by the interrupt configuration and reset status block
package eirc_pkg;
   typedef enum logic [2:0] {
      EIRC_DET_OFF,
      EIRC_DET_RISE,
      EIRC_DET_FALL,
      EIRC_DET_BOTH,
      EIRC_DET_HIGH,
      EIRC_DET_LOW
   } eirc_det_t;

   typedef struct packed {
      logic [2:0] sensitivity;
      logic wake_select;
   } eirc_setting_t;
endpackage : eirc_pkg

// ===== hdl/eirc_pin_detect.sv
// pin synchroniser and edge/level detector for one external interrupt
`timescale 1ns/1ps
`include "eirc_map.svh"
module eirc_pin_detect (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   input wire logic [2:0] sens,
   output logic event_hit
);
   logic sync1;
   logic sync2;
   logic prev;

   function automatic eirc_pkg::eirc_det_t det_mode(input logic [2:0] s);
      case (s)
         `EIRC_SEN_RISE: det_mode = eirc_pkg::EIRC_DET_RISE;
         `EIRC_SEN_FALL: det_mode = eirc_pkg::EIRC_DET_FALL;
         `EIRC_SEN_BOTH: det_mode = eirc_pkg::EIRC_DET_BOTH;
         `EIRC_SEN_HIGH: det_mode = eirc_pkg::EIRC_DET_HIGH;
         `EIRC_SEN_LOW: det_mode = eirc_pkg::EIRC_DET_LOW;
         default: det_mode = eirc_pkg::EIRC_DET_OFF;
      endcase
   endfunction : det_mode

   // sync1 feeds sync2 only; prev follows sync2 for edges
   always_ff @(posedge pclk or negedge presetn) begin // RULE12
      if (!presetn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev <= 1'b0;
      end else begin
         sync1 <= pin;
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin // RULE1
      if (!presetn) begin
         event_hit <= 1'b0;
      end else begin
         case (det_mode(sens))
            eirc_pkg::EIRC_DET_RISE: event_hit <= sync2 & ~prev;
            eirc_pkg::EIRC_DET_FALL: event_hit <= ~sync2 & prev;
            eirc_pkg::EIRC_DET_BOTH: event_hit <= sync2 ^ prev;
            eirc_pkg::EIRC_DET_HIGH: event_hit <= sync2;
            eirc_pkg::EIRC_DET_LOW: event_hit <= ~sync2;
            default: event_hit <= 1'b0;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   property p_rise_hit;
      @(posedge pclk) disable iff (!presetn)
      (sens == `EIRC_SEN_RISE) && sync2 && !prev |=> event_hit;
   endproperty
   a_rise_hit: assert property (p_rise_hit) // RULE1
      else $error("rising edge not detected");

   property p_off_quiet;
      @(posedge pclk) disable iff (!presetn)
      !(sens inside {`EIRC_SEN_RISE, `EIRC_SEN_FALL, `EIRC_SEN_BOTH,
                     `EIRC_SEN_HIGH, `EIRC_SEN_LOW}) |=> !event_hit;
   endproperty
   a_off_quiet: assert property (p_off_quiet) // RULE1
      else $error("disabled input produced an event");

   property p_low_level;
      @(posedge pclk) disable iff (!presetn)
      (sens == `EIRC_SEN_LOW) && !sync2 |=> event_hit;
   endproperty
   a_low_level: assert property (p_low_level) // RULE12
      else $error("low level not reported from synchronised pin");
endmodule : eirc_pin_detect

// ===== test/eirc_pin_model.sv
// far-side model: interrupt pins, reset sources, nmi and clock activation
`timescale 1ns/1ps
module eirc_pin_model (
   input wire logic pclk,
   output logic [2:0] pins,
   output logic ext_reset_n,
   output logic wdt_reset,
   output logic nmi_event,
   output logic [1:0] nmi_source,
   output logic cg_activate,
   output logic stop_mode
);
   initial begin
      pins = 3'h0;
      ext_reset_n = 1'b1;
      wdt_reset = 1'b0;
      nmi_event = 1'b0;
      nmi_source = 2'h3;
      cg_activate = 1'b0;
      stop_mode = 1'b0;
   end
   // pins move just after an edge; the design still syncs them
   task automatic set_pin(input int p, input logic v);
      @(posedge pclk);
      pins[p] <= v;
   endtask : set_pin
   task automatic ext_reset();
      @(posedge pclk);
      ext_reset_n <= 1'b0;
      repeat (5) @(posedge pclk);
      ext_reset_n <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask : ext_reset
   task automatic wdt();
      @(posedge pclk);
      wdt_reset <= 1'b1;
      @(posedge pclk);
      wdt_reset <= 1'b0;
   endtask : wdt
   // source is only qualified by the pulse; afterwards it shows junk
   task automatic nmi(input logic [1:0] s);
      @(posedge pclk);
      nmi_event <= 1'b1;
      nmi_source <= s;
      @(posedge pclk);
      nmi_event <= 1'b0;
      nmi_source <= ~s;
   endtask : nmi
   // one pulse stands for the accepted unlock pair written alone
   task automatic activate();
      @(posedge pclk);
      cg_activate <= 1'b1;
      @(posedge pclk);
      cg_activate <= 1'b0;
   endtask : activate
endmodule : eirc_pin_model

// ===== test/testbench.sv
// self-checking bench for the interrupt setting and reset status bank
`timescale 1ns/1ps
`include "eirc_map.svh"
module testbench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, stop_wake, pend, fri, irq, sw;
   logic [2:0] pins, ev, evs;
   logic ext_reset_n, wdt_reset, nmi_event, cg_activate, stop_mode;
   logic [1:0] nmi_source;
   int error_cnt = 0, n_compared = 0;
   always #12.5 pclk = ~pclk;
   eirc_pin_model eirc_pin_model_i (.pclk(pclk), .pins(pins),
      .ext_reset_n(ext_reset_n), .wdt_reset(wdt_reset),
      .nmi_event(nmi_event), .nmi_source(nmi_source),
      .cg_activate(cg_activate), .stop_mode(stop_mode));
   eirc_top eirc_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_irq_pin_1(pins[0]), .ext_irq_pin_2(pins[1]),
      .ext_irq_pin_3(pins[2]), .ext_reset_n(ext_reset_n),
      .wdt_reset(wdt_reset), .nmi_event(nmi_event),
      .nmi_source(nmi_source), .cg_activate(cg_activate),
      .stop_mode(stop_mode), .ext_irq_event(ev), .stop_wake(stop_wake),
      .cg_update_pending(pend), .flash_reset_inhibit(fri), .irq(irq));
   // ---------------------------------------------------------------
   // bus and compare helpers
   // ---------------------------------------------------------------
   function automatic logic [11:0] ba(input logic [31:0] idx);
      return {idx[9:0], 2'b00};
   endfunction : ba
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [31:0] idx,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ba(idx);
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) chk("pready", 1, 0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rchk(input string nm, input logic [31:0] idx,
                       input logic [31:0] e);
      apb(1'b0, idx, 32'h0);
      chk(nm, e, rd);
   endtask : rchk
   task automatic watch(input int n);
      sw = 1'b0;
      evs = 3'h0;
      repeat (n) begin
         @(negedge pclk);
         sw = sw | stop_wake;
         evs = evs | ev;
      end
   endtask : watch
   task automatic test_done();
      if (error_cnt == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   initial begin
      #500000;
      error_cnt++;
      test_done();
   end
   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      logic [2:0] c;
      logic [31:0] si;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk("misc rst", `EIRC_IDX_MISC, 32'h0);
      for (int p = 0; p < 3; p++) begin
         si = `EIRC_IDX_EXT_IRQ_PIN_1 + p;
         rchk("set rst", si, 32'h0);
         for (int k = 0; k < 8; k++) begin
            c = k[2:0];
            apb(1'b1, si, {24'h0, c, 5'h0});
            repeat (6) @(posedge pclk);
            apb(1'b1, `EIRC_IDX_ICLR, 32'h7);
            rchk("st idle", `EIRC_IDX_STAT, {29'h0, 3'(c == 3'h6) << p});
            eirc_pin_model_i.set_pin(p, 1'b1);
            repeat (6) @(posedge pclk);
            rchk("st rise", `EIRC_IDX_STAT,
                 {29'h0, 3'(c == 1 || c == 3 || c == 5 || c == 6) << p});
            apb(1'b1, `EIRC_IDX_ICLR, 32'h7);
            rchk("st high", `EIRC_IDX_STAT, {29'h0, 3'(c == 3'h5) << p});
            eirc_pin_model_i.set_pin(p, 1'b0);
            repeat (6) @(posedge pclk);
            rchk("st fall", `EIRC_IDX_STAT,
                 {29'h0, 3'(c == 2 || c == 3 || c == 5 || c == 6) << p});
         end
         apb(1'b1, si, 32'h0);
         apb(1'b1, `EIRC_IDX_ICLR, 32'h7);
      end
      apb(1'b0, 32'h1, 32'h0);
      chk("unmapped err", 1, err);
      chk("unmapped data", 0, rd);
      // wake-up only from the pin whose own select bit is set
      eirc_pin_model_i.stop_mode <= 1'b1;
      apb(1'b1, `EIRC_IDX_EXT_IRQ_PIN_2, 32'h28);
      apb(1'b1, `EIRC_IDX_EXT_IRQ_PIN_1, 32'h20);
      eirc_pin_model_i.set_pin(1, 1'b1);
      watch(8);
      chk("wake pin2", 1, sw);
      chk("ev pin2", 0, evs);
      eirc_pin_model_i.set_pin(0, 1'b1);
      watch(8);
      chk("wake pin1", 0, sw);
      chk("ev pin1", 3'h1, evs);
      eirc_pin_model_i.stop_mode <= 1'b0;
      eirc_pin_model_i.set_pin(0, 1'b0);
      eirc_pin_model_i.set_pin(1, 1'b0);
      apb(1'b1, `EIRC_IDX_ICLR, 32'h1f);
      // watchdog event: flag, interrupt, mask, clear, settings wiped
      apb(1'b1, `EIRC_IDX_IEN, 32'h08);
      eirc_pin_model_i.wdt();
      repeat (4) @(posedge pclk);
      chk("irq on", 1, irq);
      rchk("st wdt", `EIRC_IDX_STAT, 32'h08);
      rchk("set wiped", `EIRC_IDX_EXT_IRQ_PIN_2, 32'h0);
      rchk("wdr set", `EIRC_IDX_MISC, 32'h20);
      apb(1'b1, `EIRC_IDX_IEN, 32'h0);
      repeat (2) @(posedge pclk);
      chk("irq masked", 0, irq);
      apb(1'b1, `EIRC_IDX_ICLR, 32'h1f);
      apb(1'b1, `EIRC_IDX_IEN, 32'h08);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 0, irq);
      rchk("en rb", `EIRC_IDX_IEN, 32'h08);
      // flash part: bits 7..5 survive a normal reset
      apb(1'b1, `EIRC_IDX_MISC, 32'he0);
      rchk("misc w1", `EIRC_IDX_MISC, 32'he0);
      chk("fri out", 1, fri);
      eirc_pin_model_i.ext_reset();
      rchk("misc ext", `EIRC_IDX_MISC, 32'he0);
      chk("fri kept", 1, fri);
      apb(1'b1, `EIRC_IDX_MISC, 32'h00);
      rchk("misc clr", `EIRC_IDX_MISC, 32'h0);
      for (int s = 2; s >= 0; s--) begin
         eirc_pin_model_i.nmi(2'(s));
         repeat (3) @(posedge pclk);
         rchk("nmi cause", `EIRC_IDX_MISC, 32'(s) << 1);
      end
      // busy window after activation
      eirc_pin_model_i.activate();
      apb(1'b1, `EIRC_IDX_EXT_IRQ_PIN_3, 32'h60);
      chk("busy", 1, pend);
      for (int n = 0; n < 40 && pend !== 1'b0; n++) @(posedge pclk);
      chk("busy end", 0, pend);
      rchk("busy wr", `EIRC_IDX_EXT_IRQ_PIN_3, 32'h0);
      apb(1'b1, `EIRC_IDX_EXT_IRQ_PIN_3, 32'h60);
      rchk("idle wr", `EIRC_IDX_EXT_IRQ_PIN_3, 32'h60);
      // power-on reset clears the misc register and the inhibit output
      apb(1'b1, `EIRC_IDX_MISC, 32'hc0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk("por misc", `EIRC_IDX_MISC, 32'h0);
      chk("por fri", 0, fri);
      test_done();
   end
endmodule : testbench
